/* File: shared/rtc_ctl_defines.svh */
`ifndef RTC_CTL_DEFINES_SVH
`define RTC_CTL_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_ALARM_AND_INTERRUPT_CONTROL 4'he
`define ADDR_FORMAT_FLAGS_AND_ADJUST 4'hf

// ****************************************
// Field positions in the flag and control register
// ****************************************
`define FLD_HOUR_24 5
`define FLD_ADJUST_HALT 4
`define FLD_CLOCK_DISABLE 3
`define FLD_PERIODIC_FLAG 2
`define FLD_FIRST_ALARM_FLAG 1
`define FLD_SECOND_ALARM_FLAG 0

// ****************************************
// Reset values
// ****************************************
`define CTRL_RESET 8'h00
`define HALT_FLAG_RESET 1'b1

// ****************************************
// Timing, in crystal ticks, hertz and nanoseconds
// ****************************************
`define XTAL_HZ_DEFAULT 32768
`define XTAL_HZ_ALT 32000
`define LOW_TICKS_DEFAULT 16384
`define LOW_TICKS_ALT 15872
`define PULSE_LAG_NS 92000
`define PULSE_LAG_TICKS ((64'd`PULSE_LAG_NS * 64'd`XTAL_HZ_DEFAULT + 64'd500000000) / 64'd1000000000)

`endif

/* File: shared/rtc_ctl_pkg.sv */
package rtc_ctl_pkg;

    // ****************************************
    // Periodic cycle select, in register order
    // ****************************************
    typedef enum logic [2:0] {
        CYC_OFF,
        CYC_FIXED_LOW,
        CYC_PULSE_2HZ,
        CYC_PULSE_1HZ,
        CYC_LEVEL_SECOND,
        CYC_LEVEL_MINUTE,
        CYC_LEVEL_HOUR,
        CYC_LEVEL_MONTH
    } cycle_e;

    // ****************************************
    // Alarm and interrupt control register
    // ****************************************
    typedef struct packed {
        logic first_alarm_enable;
        logic second_alarm_enable;
        logic route_select_high;
        logic route_select_low;
        logic test;
        cycle_e cycle_select;
    } ctrl_s;

    // ****************************************
    // Events from the time counters
    // ****************************************
    typedef struct packed {
        logic minute_carry;
        logic hour_carry;
        logic month_carry;
        logic first_alarm_match;
        logic second_alarm_match;
    } time_events_s;

endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/1ps

module pin_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous pin
    input wire logic pin,
    // Filtered level and its rising edge
    output logic level,
    output logic rise
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic rise_reg;
    wire agree = (s2_reg == s3_reg);

    // Only the second stage reads the first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= agree ? s3_reg : level_reg;
            rise_reg <= agree && s3_reg && !level_reg;
        end
    end

    assign level = level_reg;
    assign rise = rise_reg;

endmodule

/* File: src/rtc_ctl.sv */
`timescale 1ns/1ps
`include "rtc_ctl_defines.svh"

// Functional notes
// - Control register at Eh, documented layout
// - Alarm enables gate match action, default off
// - Route 00 and 01 pin assignments
// - Route 10 and 11 pin assignments
// - Select 000 off, 001 fixed low
// - Selects 010/011 give 2Hz/1Hz squares
// - Level selects fire second/minute/hour/month
// - Level falling edge meets seconds increment
// - Alternate crystal uses 0.496s low halves
// - Trimming corrects timing every twenty seconds
// - Pulse edge lags seconds increment slightly
// - Flag register at Fh, documented layout
// - Halt gives halt one, flags zero
// - Hour format: zero 12-hour, one 24-hour
// - Adjust clears sub-seconds, rounds seconds
// - Halt clears control, stops A, clock B
// - Periodic flag mirrors output, level clearable
// - Alarm flags set on match, write-zero clears
module rtc_ctl
#(
    parameter int XTAL_HZ_A = `XTAL_HZ_DEFAULT,
    parameter int XTAL_HZ_B = `XTAL_HZ_ALT,
    parameter int LOW_TICKS_A = `LOW_TICKS_DEFAULT,
    parameter int LOW_TICKS_B = `LOW_TICKS_ALT
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Crystal and halt detector, asynchronous
    input wire logic XTAL_CLK,
    input wire logic OSC_HALT,
    input wire logic CRYSTAL_SELECT,
    // Register access from the serial interface
    input wire logic REG_WR,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Counter and trimming side
    input wire rtc_ctl_pkg::time_events_s TIME_EVENTS,
    input wire logic TRIM_STEP,
    input wire logic signed [7:0] TRIM_TICKS,
    output logic SEC_INC,
    output logic SEC_ADJUST,
    output logic HOUR_24_MODE,
    // Open-drain pins
    output logic IRQ_PIN_FIRST_OUT,
    output logic IRQ_PIN_FIRST_OE_N,
    output logic IRQ_PIN_SECOND_OUT,
    output logic IRQ_PIN_SECOND_OE_N
);
    import rtc_ctl_pkg::*;

    // ****************************************
    // Synchronised pins
    // ****************************************
    logic xtal_level;
    logic xtal_rise;
    logic halt_level;

    pin_sync xtal_sync (.clk(CLK), .rst_n(RST_N), .pin(XTAL_CLK), .level(xtal_level), .rise(xtal_rise));
    pin_sync halt_sync (.clk(CLK), .rst_n(RST_N), .pin(OSC_HALT), .level(halt_level), .rise());

    // ****************************************
    // State
    // ****************************************
    ctrl_s ctrl_reg;
    logic hour_24_reg;
    logic clock_disable_reg;
    logic halt_flag_reg;
    logic level_latch_reg;
    logic periodic_flag_reg;
    logic first_alarm_flag_reg;
    logic second_alarm_flag_reg;
    logic [15:0] cnt_reg;
    logic [15:0] limit_reg;
    logic trim_pending_reg;
    logic signed [7:0] trim_reg;
    logic sec_inc_reg;
    logic adjust_reg;
    logic [7:0] rdata_reg;
    logic pin_a_oe_n_reg;
    logic pin_b_oe_n_reg;

    // ****************************************
    // Decode
    // ****************************************
    wire wr_ctrl = REG_WR && (REG_ADDR == `ADDR_ALARM_AND_INTERRUPT_CONTROL);
    wire wr_flags = REG_WR && (REG_ADDR == `ADDR_FORMAT_FLAGS_AND_ADJUST);
    wire adjust_req = wr_flags && REG_WDATA[`FLD_ADJUST_HALT] && !halt_flag_reg;
    cycle_e sel;
    assign sel = ctrl_reg.cycle_select;
    wire level_mode = (sel == CYC_LEVEL_SECOND) || (sel == CYC_LEVEL_MINUTE)
        || (sel == CYC_LEVEL_HOUR) || (sel == CYC_LEVEL_MONTH);

    // Halt flag: detector set wins over a clearing write
    wire halt_flag_next = halt_level ? 1'b1 : (wr_flags ? 1'b0 : halt_flag_reg);
    // Halt forces every control bit, route and test to zero
    wire ctrl_s ctrl_next = halt_flag_reg ? ctrl_s'(`CTRL_RESET)
        : (wr_ctrl ? ctrl_s'(REG_WDATA) : ctrl_reg);
    wire clock_disable_next = halt_flag_reg ? 1'b0
        : (wr_flags ? REG_WDATA[`FLD_CLOCK_DISABLE] : clock_disable_reg);
    wire hour_24_next = wr_flags ? REG_WDATA[`FLD_HOUR_24] : hour_24_reg;

    // ****************************************
    // Sub-second prescaler on crystal ticks
    // ****************************************
    wire [15:0] period = CRYSTAL_SELECT ? 16'(XTAL_HZ_B) : 16'(XTAL_HZ_A);
    wire [15:0] low_ticks = CRYSTAL_SELECT ? 16'(LOW_TICKS_B) : 16'(LOW_TICKS_A);
    wire [15:0] quarter = {1'b0, low_ticks[15:1]};
    wire [15:0] base_limit = period - 16'h0001;
    // Trim shifts one second's length; positive shortens it
    wire [15:0] trim_limit = base_limit - 16'({{8{trim_reg[7]}}, trim_reg});
    wire wrap = xtal_rise && (cnt_reg >= limit_reg);
    wire [15:0] cnt_next = adjust_req ? 16'h0000
        : (wrap ? 16'h0000 : (xtal_rise ? cnt_reg + 16'h0001 : cnt_reg));
    wire [15:0] limit_next = adjust_req ? base_limit
        : (wrap ? (trim_pending_reg ? trim_limit : base_limit) : limit_reg);
    wire trim_pending_next = TRIM_STEP ? 1'b1 : (wrap ? 1'b0 : trim_pending_reg);
    wire signed [7:0] trim_next = TRIM_STEP ? TRIM_TICKS : trim_reg;

    // Pulse phase trails the seconds boundary by a few ticks
    wire [15:0] lag = 16'(`PULSE_LAG_TICKS);
    wire [15:0] offs = (cnt_reg >= lag) ? (cnt_reg - lag) : (cnt_reg + limit_reg + 16'h0001 - lag);
    wire low_1hz = offs < low_ticks;
    wire low_2hz = (offs < quarter) || ((offs >= low_ticks) && (offs < low_ticks + quarter));

    // ****************************************
    // Periodic output
    // ****************************************
    wire level_event = (sel == CYC_LEVEL_SECOND) ? sec_inc_reg
        : (sel == CYC_LEVEL_MINUTE) ? TIME_EVENTS.minute_carry
        : (sel == CYC_LEVEL_HOUR) ? TIME_EVENTS.hour_carry
        : (sel == CYC_LEVEL_MONTH) ? TIME_EVENTS.month_carry : 1'b0;
    wire level_clear = wr_flags && !REG_WDATA[`FLD_PERIODIC_FLAG];
    // Event set wins over a clearing write in the same cycle
    wire level_latch_next = !level_mode ? 1'b0
        : (level_event ? 1'b1 : (level_clear ? 1'b0 : level_latch_reg));
    wire periodic_next = (sel == CYC_FIXED_LOW) || ((sel == CYC_PULSE_2HZ) && low_2hz)
        || ((sel == CYC_PULSE_1HZ) && low_1hz) || level_latch_next;

    // ****************************************
    // Alarm flags
    // ****************************************
    wire a_clear = wr_flags && !REG_WDATA[`FLD_FIRST_ALARM_FLAG];
    wire b_clear = wr_flags && !REG_WDATA[`FLD_SECOND_ALARM_FLAG];
    wire first_alarm_next = !ctrl_reg.first_alarm_enable ? 1'b0
        : (TIME_EVENTS.first_alarm_match ? 1'b1 : (a_clear ? 1'b0 : first_alarm_flag_reg));
    wire second_alarm_next = !ctrl_reg.second_alarm_enable ? 1'b0
        : (TIME_EVENTS.second_alarm_match ? 1'b1 : (b_clear ? 1'b0 : second_alarm_flag_reg));

    // ****************************************
    // Pin routing
    // ****************************************
    wire [1:0] route = {ctrl_reg.route_select_high, ctrl_reg.route_select_low};
    // Zero route is also the single-pin variant's only legal setting
    wire b_on_a = (route == 2'b00) || (route == 2'b10);
    wire per_on_a = (route == 2'b00) || (route == 2'b01);
    wire src_a = !halt_flag_reg && (first_alarm_flag_reg || (b_on_a && second_alarm_flag_reg)
        || (per_on_a && periodic_flag_reg));
    wire src_b = (!b_on_a && second_alarm_flag_reg) || (!per_on_a && periodic_flag_reg)
        || (!clock_disable_reg && !xtal_level);

    wire [7:0] rdata_next = (REG_ADDR == `ADDR_ALARM_AND_INTERRUPT_CONTROL) ? 8'(ctrl_reg)
        : (REG_ADDR == `ADDR_FORMAT_FLAGS_AND_ADJUST)
        ? {2'b00, hour_24_reg, halt_flag_reg, clock_disable_reg, periodic_flag_reg,
           first_alarm_flag_reg, second_alarm_flag_reg} : 8'h00;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_reg <= ctrl_s'(`CTRL_RESET);
            hour_24_reg <= 1'b0;
            clock_disable_reg <= 1'b0;
            halt_flag_reg <= `HALT_FLAG_RESET;
            level_latch_reg <= 1'b0;
            periodic_flag_reg <= 1'b0;
            first_alarm_flag_reg <= 1'b0;
            second_alarm_flag_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            hour_24_reg <= hour_24_next;
            clock_disable_reg <= clock_disable_next;
            halt_flag_reg <= halt_flag_next;
            level_latch_reg <= level_latch_next;
            periodic_flag_reg <= periodic_next;
            first_alarm_flag_reg <= first_alarm_next;
            second_alarm_flag_reg <= second_alarm_next;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cnt_reg <= 16'h0000;
            limit_reg <= 16'(XTAL_HZ_A - 1);
            trim_pending_reg <= 1'b0;
            trim_reg <= 8'sh00;
            sec_inc_reg <= 1'b0;
            adjust_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            limit_reg <= limit_next;
            trim_pending_reg <= trim_pending_next;
            trim_reg <= trim_next;
            sec_inc_reg <= wrap && !adjust_req;
            adjust_reg <= adjust_req;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rdata_reg <= 8'h00;
            pin_a_oe_n_reg <= 1'b1;
            pin_b_oe_n_reg <= 1'b1;
        end
        else
        begin
            rdata_reg <= rdata_next;
            pin_a_oe_n_reg <= !src_a;
            pin_b_oe_n_reg <= !src_b;
        end
    end

    // Open-drain pins only ever drive low
    assign IRQ_PIN_FIRST_OUT = 1'b0;
    assign IRQ_PIN_SECOND_OUT = 1'b0;
    assign IRQ_PIN_FIRST_OE_N = pin_a_oe_n_reg;
    assign IRQ_PIN_SECOND_OE_N = pin_b_oe_n_reg;
    assign REG_RDATA = rdata_reg;
    assign SEC_INC = sec_inc_reg;
    assign SEC_ADJUST = adjust_reg;
    assign HOUR_24_MODE = hour_24_reg;

endmodule

/* File: test/xtal_model.sv */
`timescale 1ns/1ps

// ****************************************
// Crystal and halt detector model
// ****************************************
module xtal_model
(
    // Control from the bench
    input wire logic run,
    // Pins into the block
    output logic xtal_clk,
    output logic osc_halt
);
    // A stopped crystal sits low, never at its last level
    initial
    begin
        xtal_clk = 1'b0;
        forever
        begin
            #62.5;
            xtal_clk = run ? ~xtal_clk : 1'b0;
        end
    end
    assign osc_halt = ~run;
endmodule

/* File: test/rtc_ctl_checker.sv */
`timescale 1ns/1ps

module rtc_ctl_checker
#(
    parameter int XTAL_HZ_A = 32768,
    parameter int XTAL_HZ_B = 32000,
    parameter int LOW_TICKS_A = 16384,
    parameter int LOW_TICKS_B = 15872
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Crystal side
    input wire logic XTAL_CLK,
    input wire logic OSC_HALT,
    input wire logic CRYSTAL_SELECT,
    // Registers
    input wire logic REG_WR,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    // Counter side
    input wire rtc_ctl_pkg::time_events_s TIME_EVENTS,
    input wire logic TRIM_STEP,
    input wire logic signed [7:0] TRIM_TICKS,
    input wire logic SEC_INC,
    input wire logic SEC_ADJUST,
    input wire logic HOUR_24_MODE,
    // Pins
    input wire logic IRQ_PIN_FIRST_OUT,
    input wire logic IRQ_PIN_FIRST_OE_N,
    input wire logic IRQ_PIN_SECOND_OUT,
    input wire logic IRQ_PIN_SECOND_OE_N
);
    import rtc_ctl_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire wr_f = REG_WR && REG_ADDR == 4'hf;
    wire adj_wr = wr_f && REG_WDATA[4];

    chk_pins_open_drain: assert property (!IRQ_PIN_FIRST_OUT && !IRQ_PIN_SECOND_OUT)
        else $error("pin data not low");
    chk_inc_one_cycle: assert property (SEC_INC |=> !SEC_INC)
        else $error("second pulse too long");
    chk_adj_cause: assert property (SEC_ADJUST |-> $past(adj_wr) || $past(adj_wr, 2))
        else $error("adjust without write");
    chk_adj_one_cycle: assert property (SEC_ADJUST |=> !SEC_ADJUST)
        else $error("adjust pulse too long");
    chk_hour_format: assert property (wr_f |=> HOUR_24_MODE == $past(REG_WDATA[5]))
        else $error("hour format not taken");
    chk_unmapped_zero: assert property ($past(REG_ADDR) < 4'he |-> REG_RDATA == 8'h00)
        else $error("other address not zero");
    chk_flag_top_zero: assert property ($past(REG_ADDR) == 4'hf |-> REG_RDATA[7:6] == 2'h0)
        else $error("flag register top bits set");
    chk_halt_stops_a: assert property (OSC_HALT [*8] |=> IRQ_PIN_FIRST_OE_N)
        else $error("pin A driven while halted");
    chk_halt_ctrl_clear: assert property (OSC_HALT [*8] ##0 REG_ADDR == 4'he |=> REG_RDATA == 8'h00)
        else $error("control kept while halted");
    chk_halt_flag_read: assert property (OSC_HALT [*8] ##0 REG_ADDR == 4'hf |=> REG_RDATA[4:0] == 5'h10)
        else $error("halt flag read wrong");

    cov_second_tick: cover property (SEC_INC);
    cov_adjust: cover property (SEC_ADJUST);
    cov_pin_a_low: cover property ($fell(IRQ_PIN_FIRST_OE_N));
endmodule

bind rtc_ctl rtc_ctl_checker #(.XTAL_HZ_A(XTAL_HZ_A), .XTAL_HZ_B(XTAL_HZ_B), .LOW_TICKS_A(LOW_TICKS_A),
    .LOW_TICKS_B(LOW_TICKS_B)) rtc_ctl_checker_inst (.CLK(CLK), .RST_N(RST_N), .XTAL_CLK(XTAL_CLK),
    .OSC_HALT(OSC_HALT), .CRYSTAL_SELECT(CRYSTAL_SELECT), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TIME_EVENTS(TIME_EVENTS), .TRIM_STEP(TRIM_STEP),
    .TRIM_TICKS(TRIM_TICKS), .SEC_INC(SEC_INC), .SEC_ADJUST(SEC_ADJUST), .HOUR_24_MODE(HOUR_24_MODE),
    .IRQ_PIN_FIRST_OUT(IRQ_PIN_FIRST_OUT), .IRQ_PIN_FIRST_OE_N(IRQ_PIN_FIRST_OE_N),
    .IRQ_PIN_SECOND_OUT(IRQ_PIN_SECOND_OUT), .IRQ_PIN_SECOND_OE_N(IRQ_PIN_SECOND_OE_N));

/* File: test/test_rtc_ctl.sv */
`timescale 1ns/1ps

module test_rtc_ctl;
    import rtc_ctl_pkg::*;
    // Short seconds keep the run brief
    localparam int HZ_A = 64;
    localparam int HZ_B = 62;
    localparam int LOW_A = 32;
    localparam int LOW_B = 31;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic run = 1'b1;
    logic csel = 1'b0;
    logic wr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    time_events_s ev = '0;
    logic trim_step = 1'b0;
    logic signed [7:0] trim_ticks = 8'sh00;
    logic [7:0] rdata;
    logic xclk, halt, sinc, sadj, h24, a_out, a_oe_n, b_out, b_oe_n;
    logic [31:0] seed = 32'hb43a_6922;
    int n_errors = 0;
    int n_compared = 0;
    int n_adj = 0;

    xtal_model xtal_model_inst (.run(run), .xtal_clk(xclk), .osc_halt(halt));
    rtc_ctl #(.XTAL_HZ_A(HZ_A), .XTAL_HZ_B(HZ_B), .LOW_TICKS_A(LOW_A), .LOW_TICKS_B(LOW_B)) rtc_ctl_inst (
        .CLK(clk), .RST_N(rst_n), .XTAL_CLK(xclk), .OSC_HALT(halt), .CRYSTAL_SELECT(csel),
        .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .TIME_EVENTS(ev),
        .TRIM_STEP(trim_step), .TRIM_TICKS(trim_ticks), .SEC_INC(sinc), .SEC_ADJUST(sadj), .HOUR_24_MODE(h24),
        .IRQ_PIN_FIRST_OUT(a_out), .IRQ_PIN_FIRST_OE_N(a_oe_n), .IRQ_PIN_SECOND_OUT(b_out),
        .IRQ_PIN_SECOND_OE_N(b_oe_n));

    initial forever #2 clk = ~clk;
    always @(posedge clk) if (sadj === 1'b1) n_adj++;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int cyc(input int ticks);
        return ticks * 125 / 4;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check(rdata, e);
    endtask
    task automatic ev_pulse(input logic [4:0] e);
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = '0;
        settle();
    endtask
    task automatic wait_inc();
        for (int i = 0; i < 4000 && sinc !== 1'b1; i++) @(negedge clk);
        check(sinc, 1'b1);
    endtask
    task automatic pulse_check(input logic [7:0] ctl, input int low);
        int n;
        wr_reg(4'he, ctl);
        wait_inc();
        for (n = 0; n < 300 && a_oe_n !== 1'b0; n++) @(negedge clk);
        check(n > cyc(3) - 12 && n < cyc(3) + 12, 1'b1);
        for (n = 0; n < 3000 && a_oe_n === 1'b0; n++) @(negedge clk);
        check(n > low - 12 && n < low + 12, 1'b1);
    endtask
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        logic [7:0] v;
        logic [1:0] r;
        int n;
        int t;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(4'hf, 8'h10);
        rd_chk(4'he, 8'h00);
        rd_chk(4'h3, 8'h00);
        wr_reg(4'he, 8'hc7);
        rd_chk(4'he, 8'h00);
        n = 0;
        repeat (100) @(negedge clk) n += (b_oe_n === 1'b0);
        check(n > 30 && n < 70, 1'b1);
        check(a_oe_n, 1'b1);
        wr_reg(4'hf, 8'h00);
        rd_chk(4'hf, 8'h00);
        repeat (8)
        begin
            seed = lfsr(seed);
            // Test bit and cycle select kept clear so no flag can rise
            v = seed[7:0] & 8'hf0;
            wr_reg(4'he, v);
            rd_chk(4'he, v);
            wr_reg(4'hf, {2'h0, seed[13], 1'b0, seed[11], 3'h7});
            rd_chk(4'hf, {2'h0, seed[13], 1'b0, seed[11], 3'h0});
            check(h24, seed[13]);
        end
        for (int k = 0; k < 4; k++)
        begin
            r = k[1:0];
            wr_reg(4'he, {2'h3, r, 4'h0});
            wr_reg(4'hf, 8'h08);
            ev_pulse(5'h02);
            check({a_oe_n, b_oe_n}, 2'h1);
            rd_chk(4'hf, 8'h0a);
            ev_pulse(5'h01);
            check({a_oe_n, b_oe_n}, {1'b0, ~r[0]});
            wr_reg(4'hf, 8'h08);
            settle();
            check({a_oe_n, b_oe_n}, 2'h3);
            wr_reg(4'he, {2'h0, r, 4'h1});
            settle();
            check({a_oe_n, b_oe_n}, {r[1], ~r[1]});
            rd_chk(4'hf, 8'h0c);
            wr_reg(4'he, 8'h00);
            settle();
            check({a_oe_n, b_oe_n}, 2'h3);
        end
        ev_pulse(5'h02);
        rd_chk(4'hf, 8'h08);
        wr_reg(4'he, 8'h04);
        wait_inc();
        settle();
        check(a_oe_n, 1'b0);
        for (int k = 5; k < 9; k++)
        begin
            wr_reg(4'hf, 8'h08);
            settle();
            check(a_oe_n, 1'b1);
            if (k < 8)
            begin
                wr_reg(4'he, k[7:0]);
                ev_pulse(5'h10 >> (k - 5));
                check(a_oe_n, 1'b0);
            end
        end
        pulse_check(8'h03, cyc(LOW_A));
        pulse_check(8'h02, cyc(HZ_A / 4));
        csel = 1'b1;
        pulse_check(8'h03, cyc(LOW_B));
        csel = 1'b0;
        n_adj = 0;
        wr_reg(4'hf, 8'h18);
        settle();
        check(16'(n_adj), 16'h0001);
        // Trim lands on the wrap after the step, so only the following second changes
        seed = lfsr(seed);
        t = int'(seed[2:0]) - 4;
        @(negedge clk);
        trim_ticks = 8'(t);
        trim_step = 1'b1;
        @(negedge clk);
        trim_step = 1'b0;
        wait_inc();
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (sinc !== 1'b1 && n < 4000);
        check(n > cyc(HZ_A - t) - 4 && n < cyc(HZ_A - t) + 4, 1'b1);
        run = 1'b0;
        repeat (20) @(negedge clk);
        rd_chk(4'he, 8'h00);
        rd_chk(4'hf, 8'h10);
        check({a_oe_n, b_oe_n}, 2'h2);
        run = 1'b1;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(4'hf, 8'h10);
        end_sim();
    end

    initial
    begin
        #400000;
        n_errors++;
        end_sim();
    end
endmodule
